// *** blink_timer.sv ***
`default_nettype none
module blink_timer
    import fault_ind_pkg::*;
#(
    parameter int HALF_PERIOD = HALF_CYC
) (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Half-period tick and 2 Hz phase.
    output logic      tick,
    output logic      phase
);
    typedef struct packed {
        logic [24:0] cnt;
        logic        tick;
        logic        phase;
    } blink_st_t;

    blink_st_t cur_reg, cur_next;

    // One counter paces both the pulses and the gap after a burst.
    always_comb begin
        cur_next      = cur_reg;
        cur_next.tick = 1'b0;
        if (cur_reg.cnt == 25'(HALF_PERIOD - 1)) begin
            cur_next.cnt   = '0;
            cur_next.tick  = 1'b1;
            cur_next.phase = ~cur_reg.phase;
        end else begin
            cur_next.cnt = cur_reg.cnt + 25'h0000001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign tick  = cur_reg.tick;
    assign phase = cur_reg.phase;
endmodule : blink_timer
`default_nettype wire

// *** drive_fault_indicator_log.sv ***
`default_nettype none
module drive_fault_indicator_log
    import fault_ind_pkg::*;
#(
    parameter int HALF_PERIOD = HALF_CYC
) (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Monitors: overload, external, overvolt, overcurrent, overtemp.
    input  wire logic [4:0]  fault_in,
    input  wire logic        mains_undervolt,
    input  wire logic        cpu_comm_fault,
    // Enable inputs.
    input  wire logic        run_forward_cmd,
    input  wire logic        run_reverse_cmd,
    input  wire logic        run_enable_cmd,
    // Keypad.
    input  wire logic        key_stop,
    input  wire logic        key_view_enter,
    input  wire logic        key_view_exit,
    input  wire logic        key_up,
    output logic [7:0]       keypad_code,
    output logic [2:0]       keypad_dp,
    // Indicators and drive.
    output logic             run_led,
    output logic             status_led,
    output logic             fault_led,
    output logic             relay_closed,
    output logic             drive_run,
    output logic             irq
);
    typedef struct packed {
        drive_state_t state;
        logic [4:0]   slot;
        logic [2:0]   fidx;
        logic         en_low_seen;
        logic [3:0]   irq_stat;
        logic [3:0]   irq_mask;
        logic [31:0]  prdata;
        logic         hist_rd;
        logic         view_on;
        logic [1:0]   view_idx;
        logic         run_led;
        logic         status_led;
        logic         fault_led;
        logic         relay;
        logic         run;
    } main_st_t;

    main_st_t   cur_reg, cur_next;
    logic       tick;
    logic       phase;
    logic       push;
    logic [7:0] push_code;
    logic [7:0] hist_q;
    logic       enable_any;
    logic       any_fault;
    logic [2:0] new_idx;
    logic       apb_setup;
    logic       apb_wr;
    logic       hist_hit;
    logic       map_hit;
    logic       ser_reset;
    logic [4:0] burst_slots;
    logic [4:0] period_slots;
    logic [3:0] irq_set;

    blink_timer #(
        .HALF_PERIOD(HALF_PERIOD)
    ) u_blink (
        .pclk   (pclk),
        .presetn(presetn),
        .tick   (tick),
        .phase  (phase)
    );

    fault_history_mem u_hist (
        .pclk     (pclk),
        .presetn  (presetn),
        .push     (push),
        .push_code(push_code),
        .rd_addr_a(paddr[4:2]),
        .rd_data_a(hist_q),
        .rd_addr_b({1'b0, cur_next.view_idx}),
        .rd_data_b(keypad_code)
    );

    // Any of the three enable inputs counts as the enable signal.
    assign enable_any = run_forward_cmd | run_reverse_cmd | run_enable_cmd;
    assign any_fault  = |fault_in;

    // Lowest-numbered monitor wins when several trip at once.
    always_comb begin
        new_idx = 3'd0;
        for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
            if (fault_in[i]) begin
                new_idx = 3'(i);
            end
        end
    end

    // Fault index to serial code.
    always_comb begin
        case (new_idx)
            3'd0:    push_code = CODE_OVERLOAD;
            3'd1:    push_code = CODE_EXTERNAL;
            3'd2:    push_code = CODE_OVERVOLT;
            3'd3:    push_code = CODE_OVERCUR;
            3'd4:    push_code = CODE_OVERTEMP;
            default: push_code = CODE_NONE;
        endcase
    end

    // Burst of fidx+1 pulses, two slots each, then the gap.
    assign burst_slots  = 5'({cur_reg.fidx, 1'b0}) + 5'd2;
    assign period_slots = burst_slots + 5'(GAP_SLOTS);

    // APB decode; the slave always answers without wait states.
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pwrite;
    assign hist_hit  = paddr >= HIST_OFS && paddr <= HIST_END_OFS
                     && paddr[1:0] == 2'b00;
    assign map_hit   = hist_hit || paddr == CTRL_OFS
                     || paddr == STATUS_OFS || paddr == IRQ_STAT_OFS
                     || paddr == IRQ_MASK_OFS;
    assign ser_reset = apb_wr && paddr == CTRL_OFS && pstrb[0]
                     && pwdata[CTRL_RESET_BIT];
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~map_hit;
    assign prdata    = cur_reg.hist_rd ? {24'h000000, hist_q}
                                       : cur_reg.prdata;

    // History is pushed once, on entry to the fault state.
    assign push = cur_reg.state != ST_FAULT && cur_next.state == ST_FAULT;

    // Main sequencing, indicators, keypad view and registers.
    always_comb begin
        cur_next = cur_reg;
        irq_set  = 4'h0;
        case (cur_reg.state)
            ST_PWRUP: begin
                // Supply alive: reds flash until the check slot.
                if (tick) begin
                    cur_next.slot = cur_reg.slot + 5'd1;
                end
                if (cur_reg.slot == 5'(PWRUP_SLOTS)) begin
                    cur_next.state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                // Operating state checked before the run LED starts.
                if (any_fault) begin
                    cur_next.state = ST_FAULT;
                end else begin
                    cur_next.state = ST_READY;
                end
                cur_next.slot = '0;
            end
            ST_READY: begin
                if (any_fault) begin
                    cur_next.state       = ST_FAULT;
                    cur_next.slot        = '0;
                    cur_next.en_low_seen = 1'b0;
                end
            end
            ST_FAULT: begin
                if (tick) begin
                    if (cur_reg.slot >= period_slots - 5'd1) begin
                        cur_next.slot = '0;
                    end else begin
                        cur_next.slot = cur_reg.slot + 5'd1;
                    end
                end
                if (!enable_any) begin
                    cur_next.en_low_seen = 1'b1;
                end
                // The monitor must be quiet before any clear is taken.
                if (!any_fault && (ser_reset || key_stop
                    || (enable_any && cur_reg.en_low_seen))) begin
                    cur_next.state = ST_READY;
                    irq_set[IRQ_CLEAR_BIT] = 1'b1;
                end
            end
            ST_UNDERV: begin
                if (!mains_undervolt) begin
                    cur_next.state = ST_PWRUP;
                    cur_next.slot  = '0;
                end
            end
            ST_CPUFAIL: begin
                // Defective unit: only a power cycle leaves this state.
                cur_next.state = ST_CPUFAIL;
            end
            default: begin
                cur_next.state = ST_PWRUP;
            end
        endcase
        if (cur_next.state == ST_FAULT && cur_reg.state != ST_FAULT) begin
            cur_next.fidx          = new_idx;
            irq_set[IRQ_FAULT_BIT] = 1'b1;
        end
        // Undervoltage overrides, the processor fault overrides all.
        if (mains_undervolt && cur_reg.state != ST_CPUFAIL
            && cur_reg.state != ST_UNDERV) begin
            cur_next.state          = ST_UNDERV;
            irq_set[IRQ_UNDERV_BIT] = 1'b1;
        end
        if (cpu_comm_fault && cur_reg.state != ST_CPUFAIL) begin
            cur_next.state       = ST_CPUFAIL;
            irq_set[IRQ_CPU_BIT] = 1'b1;
        end

        // Indicators follow the state; the run LED flashes when idle.
        cur_next.run        = 1'b0;
        cur_next.relay      = 1'b1;
        cur_next.run_led    = 1'b0;
        cur_next.status_led = 1'b0;
        cur_next.fault_led  = 1'b0;
        case (cur_reg.state)
            ST_PWRUP, ST_CHECK: begin
                cur_next.status_led = phase;
                cur_next.fault_led  = phase;
            end
            ST_READY: begin
                cur_next.run     = enable_any;
                cur_next.run_led = enable_any | phase;
            end
            ST_FAULT: begin
                cur_next.relay      = 1'b0;
                cur_next.status_led = 1'b1;
                cur_next.fault_led  = cur_reg.slot < burst_slots
                                    && !cur_reg.slot[0];
            end
            ST_UNDERV: begin
                cur_next.relay      = 1'b0;
                cur_next.status_led = phase;
                cur_next.fault_led  = phase;
            end
            ST_CPUFAIL: begin
                cur_next.relay      = 1'b0;
                cur_next.status_led = 1'b1;
                cur_next.fault_led  = 1'b1;
            end
            default: begin
                cur_next.relay = 1'b0;
            end
        endcase

        // Keypad browsing of the newest four entries.
        if (key_view_enter) begin
            cur_next.view_on  = 1'b1;
            cur_next.view_idx = 2'd0;
        end else if (key_view_exit) begin
            cur_next.view_on = 1'b0;
        end else if (key_up && cur_reg.view_on
                     && cur_reg.view_idx != 2'(KEYPAD_DEPTH - 1)) begin
            cur_next.view_idx = cur_reg.view_idx + 2'd1;
        end

        // APB read data is captured in the setup cycle.
        if (apb_setup && !pwrite) begin
            cur_next.hist_rd = hist_hit;
            case (paddr)
                STATUS_OFS: cur_next.prdata = {16'h0000,
                    cur_reg.run, cur_reg.relay, cur_reg.fault_led,
                    cur_reg.status_led, cur_reg.run_led,
                    cur_reg.state, push_code & {8{any_fault}}};
                IRQ_STAT_OFS: cur_next.prdata = {28'h0, cur_reg.irq_stat};
                IRQ_MASK_OFS: cur_next.prdata = {28'h0, cur_reg.irq_mask};
                default:      cur_next.prdata = 32'h00000000;
            endcase
        end

        // Status bits clear on a written one; a new event wins.
        if (apb_wr && paddr == IRQ_STAT_OFS && pstrb[0]) begin
            cur_next.irq_stat = cur_reg.irq_stat & ~pwdata[3:0];
        end
        cur_next.irq_stat = cur_next.irq_stat | irq_set;
        if (apb_wr && paddr == IRQ_MASK_OFS && pstrb[0]) begin
            cur_next.irq_mask = pwdata[3:0];
        end
    end

    // Every control bit has a reset value; relay open, LEDs dark.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_reg          <= '0;
            cur_reg.state    <= ST_PWRUP;
            cur_reg.irq_mask <= IRQ_MASK_RESET;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // Depth marks flash with the 2 Hz phase, one dot per step back.
    always_comb begin
        keypad_dp = 3'b000;
        for (int i = 0; i < KEYPAD_DEPTH - 1; i++) begin
            if (cur_reg.view_on && 2'(i) < cur_reg.view_idx) begin
                keypad_dp[i] = phase;
            end
        end
    end

    // The keypad window never reaches past the fourth entry.
    assign run_led      = cur_reg.run_led;
    assign status_led   = cur_reg.status_led;
    assign fault_led    = cur_reg.fault_led;
    assign relay_closed = cur_reg.relay;
    assign drive_run    = cur_reg.run;
    assign irq          = |(cur_reg.irq_stat & cur_reg.irq_mask);
endmodule : drive_fault_indicator_log
`default_nettype wire

// *** drive_fault_indicator_log_properties.sv ***
`default_nettype none
module drive_fault_props
    import fault_ind_pkg::*;
#(
    parameter int HALF_PERIOD = HALF_CYC
) (
    // Clock, reset and bus.
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    // Monitors and enables.
    input wire logic [4:0] fault_in,
    input wire logic       mains_undervolt,
    input wire logic       cpu_comm_fault,
    input wire logic       run_forward_cmd,
    input wire logic       run_reverse_cmd,
    input wire logic       run_enable_cmd,
    // Indicators.
    input wire logic [2:0] keypad_dp,
    input wire logic       run_led,
    input wire logic       status_led,
    input wire logic       fault_led,
    input wire logic       relay_closed,
    input wire logic       drive_run
);
    logic en_any;
    int   hi_cnt;
    logic cpu_seen;

    // Any of the three enable inputs counts as a run request.
    assign en_any = run_forward_cmd | run_reverse_cmd | run_enable_cmd;

    // Length of the present high run of the fault LED; a steady red after
    // a processor fault is the only legal reason for a long run.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt   <= 0;
            cpu_seen <= 1'b0;
        end else begin
            hi_cnt   <= fault_led ? hi_cnt + 1 : 0;
            cpu_seen <= cpu_seen | cpu_comm_fault;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_cpu;
        cpu_comm_fault && !mains_undervolt |->
            ##[1:3] (status_led && fault_led && !run_led);
    endproperty
    a_cpu: assert property (p_cpu)
        else $error("processor fault indication wrong");

    property p_underv;
        mains_undervolt && !cpu_comm_fault |->
            ##[1:3] (!run_led && !relay_closed && status_led == fault_led);
    endproperty
    a_underv: assert property (p_underv)
        else $error("undervoltage indication wrong");

    property p_fault;
        (|fault_in) |-> ##[1:3] !drive_run;
    endproperty
    a_fault: assert property (p_fault)
        else $error("drive kept running under a fault");

    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("bus access not completed");

    property p_slverr;
        psel && penable && paddr > HIST_END_OFS |-> pslverr;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("unmapped access not refused");

    property p_dp;
        keypad_dp inside {3'h0, 3'h1, 3'h3, 3'h7};
    endproperty
    a_dp: assert property (p_dp)
        else $error("decimal points not rightmost");

    property p_pulse;
        hi_cnt <= 2 * HALF_PERIOD + 2 || cpu_seen;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("fault LED high too long");

    property p_drive;
        drive_run |-> $past(en_any) || $past(en_any, 2);
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive runs without enable");
endmodule : drive_fault_props

bind drive_fault_indicator_log drive_fault_props #(
    .HALF_PERIOD(HALF_PERIOD)
) drive_fault_props_i (
    .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
    .fault_in, .mains_undervolt, .cpu_comm_fault, .run_forward_cmd,
    .run_reverse_cmd, .run_enable_cmd, .keypad_dp, .run_led,
    .status_led, .fault_led, .relay_closed, .drive_run
);
`default_nettype wire

// *** fault_history_mem.sv ***
`default_nettype none
module fault_history_mem
    import fault_ind_pkg::*;
(
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Push port; the newest entry lands at index zero.
    input  wire logic       push,
    input  wire logic [7:0] push_code,
    // Two registered read ports.
    input  wire logic [2:0] rd_addr_a,
    output logic [7:0]      rd_data_a,
    input  wire logic [2:0] rd_addr_b,
    output logic [7:0]      rd_data_b
);
    typedef struct packed {
        logic [HIST_DEPTH-1:0][7:0] ent;
        logic [7:0]                 qa;
        logic [7:0]                 qb;
    } hist_st_t;

    hist_st_t cur_reg, cur_next;

    // There is deliberately no clear input: only a power cycle empties it.
    always_comb begin
        cur_next    = cur_reg;
        cur_next.qa = cur_reg.ent[rd_addr_a];
        cur_next.qb = cur_reg.ent[rd_addr_b];
        if (push) begin
            cur_next.ent[0] = push_code;
        end
        for (int i = 1; i < HIST_DEPTH; i++) begin
            if (push) begin
                cur_next.ent[i] = cur_reg.ent[i-1];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign rd_data_a = cur_reg.qa;
    assign rd_data_b = cur_reg.qb;
endmodule : fault_history_mem
`default_nettype wire

// *** fault_ind_pkg.sv ***
// Summary of operation
// - Fault stops drive, status red, relay open
// - Fault LED bursts at 2 Hz, 2 s gap
// - Burst count one to five per fault type
// - Undervoltage: run off, both reds flash together
// - Power-up: reds flash, check, then run flashes
// - Processor fault: run off, both reds steady
// - No auto restart; no enable edge needed after
// - Clear by power, enable cycle, stop, serial
// - New fault pushed, newest entry first
// - History has no clear, survives defaults
// - History readable by keypad and serial bus
// - Keypad shows only four newest entries
// - Up key steps older, decimal points mark depth
// - Serial codes 04, 0B, 06, 02, 08
`default_nettype none
package fault_ind_pkg;
    // Clock and LED timing.
    localparam int CLK_HZ        = 125_000_000;
    localparam int LED_HALF_MS   = 250;
    localparam int GAP_MS        = 2000;
    localparam int HALF_CYC      = CLK_HZ / 1000 * LED_HALF_MS;
    localparam int GAP_SLOTS     = GAP_MS / LED_HALF_MS;
    localparam int PWRUP_SLOTS   = 4;
    localparam int NUM_FAULTS    = 5;
    // History depth and keypad window.
    localparam int HIST_DEPTH    = 8;
    localparam int KEYPAD_DEPTH  = 4;
    // APB register byte offsets.
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] STATUS_OFS   = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
    localparam logic [7:0] HIST_OFS     = 8'h20;
    localparam logic [7:0] HIST_END_OFS = 8'h3C;
    // Field positions.
    localparam int CTRL_RESET_BIT = 0;
    localparam int IRQ_FAULT_BIT  = 0;
    localparam int IRQ_UNDERV_BIT = 1;
    localparam int IRQ_CPU_BIT    = 2;
    localparam int IRQ_CLEAR_BIT  = 3;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    // Serial fault codes, indexed by burst count minus one.
    localparam logic [7:0] CODE_OVERLOAD = 8'h04;
    localparam logic [7:0] CODE_EXTERNAL = 8'h0B;
    localparam logic [7:0] CODE_OVERVOLT = 8'h06;
    localparam logic [7:0] CODE_OVERCUR  = 8'h02;
    localparam logic [7:0] CODE_OVERTEMP = 8'h08;
    localparam logic [7:0] CODE_NONE     = 8'h00;

    typedef enum logic [2:0] {
        ST_PWRUP, ST_CHECK, ST_READY, ST_FAULT, ST_UNDERV, ST_CPUFAIL
    } drive_state_t;
endpackage : fault_ind_pkg
`default_nettype wire

// *** operator_panel_model.sv ***
`default_nettype none
module operator_panel_model #(
    parameter int HP = 8
) (
    // Clock and observed LED.
    input  wire logic pclk,
    input  wire logic fault_led,
    // Key pulses.
    output logic      key_stop,
    output logic      key_view_enter,
    output logic      key_view_exit,
    output logic      key_up
);
    timeunit 1ns;
    timeprecision 1ps;
    int         hi = 0;
    int         lo = 0;
    int         cnt = 0;
    int         burst = 0;
    int         gap = 0;
    int         width = 0;
    logic [3:0] keys = 4'h0;

    // Index 0 stop, 1 enter history view, 2 leave it, 3 up.
    assign {key_up, key_view_exit, key_view_enter, key_stop} = keys;

    // One key for one clock; the enter key stands for the long OK hold.
    task automatic press(input int k);
        @(posedge pclk);
        keys <= 4'h1 << k;
        @(posedge pclk);
        keys <= 4'h0;
    endtask : press

    // A dark run longer than three slots ends a burst, so the count and
    // the gap are latched at the next burst, the last pulse width as each pulse ends.
    always @(posedge pclk) begin
        if (fault_led) begin
            if (lo > 3 * HP) begin
                burst <= cnt;
                gap   <= lo;
                cnt   <= 1;
            end else if (lo > 0) begin
                cnt <= cnt + 1;
            end
            hi <= (lo > 0) ? 1 : hi + 1;
            lo <= 0;
        end else begin
            if (hi > 0) width <= hi;
            hi <= 0;
            lo <= lo + 1;
        end
    end
endmodule : operator_panel_model
`default_nettype wire

// *** tb_drive_fault_indicator_log.sv ***
`default_nettype none
module tb_drive_fault_indicator_log
    import fault_ind_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HP = 8;
    localparam logic [7:0] CODES [5] = '{CODE_OVERLOAD, CODE_EXTERNAL,
        CODE_OVERVOLT, CODE_OVERCUR, CODE_OVERTEMP};
    logic        pclk, presetn, psel, penable, pwrite, err, pv;
    logic        mains_undervolt, cpu_comm_fault, pready, pslverr;
    logic        run_led, status_led, fault_led, relay_closed, drive_run;
    logic        irq, key_stop, key_view_enter, key_view_exit, key_up;
    logic [2:0]  en, keypad_dp;
    logic [4:0]  fault_in;
    logic [7:0]  paddr, keypad_code;
    logic [31:0] pwdata, prdata, r, m;
    logic [7:0]  hist [$];
    int          failures, checks, bad, tog;

    drive_fault_indicator_log #(.HALF_PERIOD(HP)) drive_fault_indicator_log_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hF), .prdata, .pready, .pslverr, .fault_in,
        .mains_undervolt, .cpu_comm_fault, .run_forward_cmd(en[2]),
        .run_reverse_cmd(en[1]), .run_enable_cmd(en[0]), .key_stop,
        .key_view_enter, .key_view_exit, .key_up, .keypad_code,
        .keypad_dp, .run_led, .status_led, .fault_led, .relay_closed,
        .drive_run, .irq
    );
    operator_panel_model #(.HP(HP)) panel_i (
        .pclk, .fault_led, .key_stop, .key_view_enter, .key_view_exit,
        .key_up
    );

    // Free-running 125 MHz clock.
    always #4 pclk = ~pclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim

    // One transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic wait_ready();
        apb(1'b0, STATUS_OFS, 32'h0);
        for (int i = 0; i < 200 && r[10:8] !== 3'h2; i++)
            apb(1'b0, STATUS_OFS, 32'h0);
    endtask : wait_ready

    // Counts samples where the reds disagree or run is lit, and toggles.
    task automatic watch_reds(input int n, input logic steady);
        bad = 0;
        tog = 0;
        pv = status_led;
        repeat (n) begin
            @(negedge pclk);
            if (status_led !== fault_led || run_led !== 1'b0) bad++;
            if (steady && status_led !== 1'b1) bad++;
            if (status_led !== pv) tog++;
            pv = status_led;
        end
    endtask : watch_reds

    // Watchdog well beyond the expected few thousand cycles.
    initial begin
        #(8 * 30000);
        failures++;
        end_sim();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite} = '0;
        {mains_undervolt, cpu_comm_fault, en, fault_in} = '0;
        paddr = '0;
        pwdata = '0;
        void'($urandom(32'h4930));
        cyc(2);
        presetn <= 1'b1;
        apb(1'b0, STATUS_OFS, 32'h0);
        check(r[10:8], 3'h0);
        watch_reds(16, 1'b0);
        check(bad, 0);
        check(tog > 0, 1);
        wait_ready();
        check(r[10:8], 3'h2);
        apb(1'b0, IRQ_MASK_OFS, 32'h0);
        check(r, IRQ_MASK_RESET);
        m = $urandom & 32'hF;
        apb(1'b1, IRQ_MASK_OFS, m);
        apb(1'b0, IRQ_MASK_OFS, 32'h0);
        check(r, m);
        apb(1'b1, IRQ_MASK_OFS, 32'h1);
        apb(1'b0, 8'h80, 32'h0);
        check({err, r}, {1'b1, 32'h0});
        $display("done: power-up and registers");
        // Each fault type in turn, cleared by serial write, stop key or enable cycle in rotation.
        for (int n = 1; n <= 5; n++) begin
            en <= (n == 3) ? 3'h0 : 3'h1 << (n % 3);
            fault_in <= 5'h1 << (n - 1);
            cyc((2 * n + 8) * HP * 3 + 20);
            apb(1'b0, STATUS_OFS, 32'h0);
            check(r[7:0], CODES[n-1]);
            check(r[10:8], 3'h3);
            check({relay_closed, drive_run, status_led}, 3'h1);
            check(panel_i.burst, n);
            check(panel_i.gap, (GAP_SLOTS + 1) * HP);
            check(panel_i.width, HP);
            if (n == 1) begin
                check(irq, 1'b1);
                apb(1'b1, IRQ_STAT_OFS, 32'h1);
                cyc(2);
                check(irq, 1'b0);
            end
            hist.push_front(CODES[n-1]);
            fault_in <= 5'h0;
            cyc(4);
            apb(1'b0, STATUS_OFS, 32'h0);
            check(r[10:8], 3'h3);
            case (n % 3)
                1: apb(1'b1, CTRL_OFS, 32'h1);
                2: panel_i.press(0);
                default: en <= 3'h1;
            endcase
            cyc(4);
            apb(1'b0, STATUS_OFS, 32'h0);
            check(r[10:8], 3'h2);
            check(drive_run, 1'b1);
        end
        $display("done: fault bursts and clearing");
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, HIST_OFS + 8'(4 * i), 32'h0);
            check(r, (i < 5) ? hist[i] : 8'h0);
        end
        apb(1'b1, HIST_OFS, 32'hFF);
        apb(1'b0, HIST_OFS, 32'h0);
        check(r, hist[0]);
        panel_i.press(1);
        cyc(3);
        check(keypad_code, hist[0]);
        for (int i = 1; i <= 4; i++) begin
            panel_i.press(3);
            cyc(3);
            check(keypad_code, hist[(i > 3) ? 3 : i]);
        end
        panel_i.press(2);
        $display("done: history");
        mains_undervolt <= 1'b1;
        cyc(3);
        watch_reds(48, 1'b0);
        check(bad, 0);
        check(tog >= 4, 1);
        mains_undervolt <= 1'b0;
        cyc(2);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(r[10:8], 3'h0);
        wait_ready();
        cpu_comm_fault <= 1'b1;
        cyc(3);
        watch_reds(40, 1'b1);
        check(bad + tog, 0);
        cpu_comm_fault <= 1'b0;
        cyc(2);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(r[10:8], 3'h5);
        presetn <= 1'b0;
        cyc(2);
        check({relay_closed, irq, drive_run}, 3'h0);
        presetn <= 1'b1;
        wait_ready();
        check(r[10:8], 3'h2);
        $display("done: undervoltage, processor fault, reset");
        end_sim();
    end
endmodule : tb_drive_fault_indicator_log
`default_nettype wire
